// [inc/gnpr_map.vh]
`ifndef GNPR_MAP_VH
`define GNPR_MAP_VH

`define GNPR_ADDR_W          5
`define GNPR_REG_NP_TX       5'h07
`define GNPR_REG_LP_NP       5'h08
`define GNPR_REG_GIG_CTRL    5'h09
`define GNPR_REG_GIG_STAT    5'h0a

`define GNPR_NP_TX_RESET     16'h2001
`define GNPR_NP_TX_WMASK     16'hb7ff
`define GNPR_NP_TOGGLE_BIT   11
`define GNPR_GIG_CTRL_RESET  16'h0000
`define GNPR_GIG_CTRL_WMASK  16'hff00

`define GNPR_CTRL_ADV_HD     8
`define GNPR_CTRL_ADV_FD     9
`define GNPR_CTRL_PORT_TYPE  10
`define GNPR_CTRL_CFG_VAL    11
`define GNPR_CTRL_MAN_EN     12
`define GNPR_CTRL_TEST_LSB   13

`define GNPR_TEST_NORMAL     3'h0
`define GNPR_TEST_WAVEFORM   3'h1
`define GNPR_TEST_JIT_MST    3'h2
`define GNPR_TEST_JIT_SLV    3'h3
`define GNPR_TEST_DISTORT    3'h4

`endif

// [hdl/gnpr_fault_latch.v]
`timescale 1ns/1ps
`default_nettype none
// Latch-high, clear-on-read flag; a new event wins over the read clear
module gnpr_fault_latch (
    input  wire ref_clk,
    input  wire rst,
    input  wire soft_rst,
    input  wire set_evt,
    input  wire rd_clr,
    output wire flag
);
    reg flag_ff;
    wire nxt_flag;

    assign nxt_flag = set_evt | (flag_ff & ~rd_clr);

    always @(posedge ref_clk) begin
        if (rst || soft_rst) begin
            flag_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    assign flag = flag_ff;
endmodule
`default_nettype wire

// [hdl/gnpr_regs.v]
// Behaviour
// - Next-page transmit bits 10:0 writable message field, reset 0x001.
// - Transmit bit 11 is toggle, read-only, reset zero.
// - Transmit bit 12 writable second acknowledge, reset zero.
// - Transmit bit 13 writable message page resets one; bit 14 reads zero.
// - Transmit bit 15 writable next-page flag, reset zero.
// - Partner next-page register wholly read-only, received word, zero after reset.
// - Control bit 10 port-type preference: one master, zero slave.
// - Control bit 11 forced role under manual configuration: one master.
// - Control bit 12 enables manual master/slave configuration.
// - Control bits 15:13 test mode, codes 0 to 4, others reserved.
// - Status bits 10, 11 show partner gigabit half and full duplex.
// - Status bit 12 shows remote receiver good.
// - Status bit 13 shows local receiver good.
// - Status bit 14 shows resolved role, one master.
// - Status bit 15 latched fault, cleared on read, reset zero.
// - Access only through the management control port, routed by address.
`timescale 1ns/1ps
`default_nettype none
`include "gnpr_map.vh"
module gnpr_regs (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        soft_rst,
    input  wire        mgmt_req,
    input  wire        mgmt_wr,
    input  wire [4:0]  mgmt_addr,
    input  wire [15:0] mgmt_wdata,
    output reg  [15:0] mgmt_rdata,
    output reg         mgmt_ack,
    input  wire        np_toggle,
    input  wire [15:0] lp_np_word,
    input  wire        lp_np_load,
    input  wire        lp_gig_hd,
    input  wire        lp_gig_fd,
    input  wire        remote_rx_ok,
    input  wire        local_rx_ok,
    input  wire        ms_is_master,
    input  wire        ms_fault_evt,
    input  wire [7:0]  idle_err_cnt,
    output wire [15:0] np_tx_word,
    output wire        adv_gig_hd,
    output wire        adv_gig_fd,
    output wire        pref_master,
    output wire        force_master,
    output wire        manual_ms_en,
    output wire [2:0]  test_mode,
    output wire        test_mode_valid
);
    reg  [15:0] np_tx_ff;
    reg  [15:0] gig_ctrl_ff;
    reg  [15:0] lp_np_ff;
    reg  [15:0] stat_ff;
    reg  [15:0] nxt_rdata;
    wire        wr_np_tx;
    wire        wr_ctrl;
    wire        rd_stat;
    wire        fault_flag;
    wire        clr;

    assign clr      = rst | soft_rst;
    assign wr_np_tx = mgmt_req & mgmt_wr & (mgmt_addr == `GNPR_REG_NP_TX);
    assign wr_ctrl  = mgmt_req & mgmt_wr & (mgmt_addr == `GNPR_REG_GIG_CTRL);
    assign rd_stat  = mgmt_req & ~mgmt_wr & (mgmt_addr == `GNPR_REG_GIG_STAT);

    // Transmit word: writable bits masked, toggle from negotiation logic
    always @(posedge ref_clk) begin
        if (clr) begin
            np_tx_ff <= `GNPR_NP_TX_RESET;
        end else begin
            if (wr_np_tx) begin
                np_tx_ff <= (mgmt_wdata & `GNPR_NP_TX_WMASK) |
                            (np_tx_ff & ~`GNPR_NP_TX_WMASK);
            end
            np_tx_ff[`GNPR_NP_TOGGLE_BIT] <= np_toggle;
            np_tx_ff[14] <= 1'b0;
        end
    end

    always @(posedge ref_clk) begin
        if (clr) begin
            gig_ctrl_ff <= `GNPR_GIG_CTRL_RESET;
        end else if (wr_ctrl) begin
            gig_ctrl_ff <= mgmt_wdata & `GNPR_GIG_CTRL_WMASK;
        end
    end

    // Received word, loaded only by negotiation logic
    always @(posedge ref_clk) begin
        if (clr) begin
            lp_np_ff <= 16'h0000;
        end else if (lp_np_load) begin
            lp_np_ff <= lp_np_word;
        end
    end

    // Status fields sampled each cycle
    always @(posedge ref_clk) begin
        if (clr) begin
            stat_ff <= 16'h0000;
        end else begin
            stat_ff <= {1'b0, ms_is_master, local_rx_ok, remote_rx_ok,
                        lp_gig_fd, lp_gig_hd, 2'b00, idle_err_cnt};
        end
    end

    gnpr_fault_latch u_fault (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .soft_rst (soft_rst),
        .set_evt  (ms_fault_evt),
        .rd_clr   (rd_stat),
        .flag     (fault_flag)
    );

    always @* begin
        case (mgmt_addr)
            `GNPR_REG_NP_TX:    nxt_rdata = np_tx_ff;
            `GNPR_REG_LP_NP:    nxt_rdata = lp_np_ff;
            `GNPR_REG_GIG_CTRL: nxt_rdata = gig_ctrl_ff;
            `GNPR_REG_GIG_STAT: nxt_rdata = {fault_flag, stat_ff[14:0]};
            default:            nxt_rdata = 16'h0000;
        endcase
    end

    // One-cycle answer to each request
    always @(posedge ref_clk) begin
        if (clr) begin
            mgmt_rdata <= 16'h0000;
            mgmt_ack   <= 1'b0;
        end else begin
            mgmt_ack <= mgmt_req;
            if (mgmt_req && !mgmt_wr) begin
                mgmt_rdata <= nxt_rdata;
            end
        end
    end

    assign np_tx_word      = np_tx_ff;
    assign adv_gig_hd      = gig_ctrl_ff[`GNPR_CTRL_ADV_HD];
    assign adv_gig_fd      = gig_ctrl_ff[`GNPR_CTRL_ADV_FD];
    assign pref_master     = gig_ctrl_ff[`GNPR_CTRL_PORT_TYPE];
    assign force_master    = gig_ctrl_ff[`GNPR_CTRL_CFG_VAL];
    assign manual_ms_en    = gig_ctrl_ff[`GNPR_CTRL_MAN_EN];
    assign test_mode       = gig_ctrl_ff[15:13];
    assign test_mode_valid = (test_mode <= `GNPR_TEST_DISTORT);
endmodule
`default_nettype wire

// [testbench/gnpr_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module gnpr_monitor (
    input wire        ref_clk,
    input wire        rst,
    input wire        soft_rst,
    input wire        mgmt_req,
    input wire        mgmt_wr,
    input wire [4:0]  mgmt_addr,
    input wire [15:0] mgmt_wdata,
    input wire [15:0] mgmt_rdata,
    input wire        mgmt_ack,
    input wire        ms_fault_evt,
    input wire [15:0] np_tx_word
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst || soft_rst);
    wire rd  = mgmt_req && !mgmt_wr;
    wire rda = rd && mgmt_addr == 5'h0a;
    ack_follow_a: assert property (mgmt_req |=> mgmt_ack) else $error("ack late");
    ack_single_a: assert property (!mgmt_req |=> !mgmt_ack) else $error("ack extra");
    np_write_a: assert property (mgmt_req && mgmt_wr && mgmt_addr == 5'h07 |=>
        (np_tx_word & 16'hb7ff) == ($past(mgmt_wdata) & 16'hb7ff)) else $error("np write");
    np_read_a: assert property (rd && mgmt_addr == 5'h07 |=>
        mgmt_rdata == $past(np_tx_word)) else $error("np read");
    fault_set_a: assert property (ms_fault_evt ##1 !rda ##1 rda |=> mgmt_rdata[15])
        else $error("fault lost");
    fault_clr_a: assert property ((rda && !ms_fault_evt) ##1 !ms_fault_evt ##1
        (rda && !ms_fault_evt) |=> !mgmt_rdata[15]) else $error("fault kept");
    stat_rsvd_a: assert property (rda |=> mgmt_rdata[9:8] == 2'h0) else $error("stat rsvd");
    ctrl_rsvd_a: assert property (rd && mgmt_addr == 5'h09 |=>
        mgmt_rdata[7:0] == 8'h00) else $error("ctrl rsvd");
    cover property (ms_fault_evt ##2 rda);
    cover property (mgmt_req && mgmt_wr && mgmt_addr == 5'h09);
    cover property (rd ##2 rd);
endmodule
bind gnpr_regs gnpr_monitor u_mon (.ref_clk(ref_clk), .rst(rst), .soft_rst(soft_rst),
    .mgmt_req(mgmt_req), .mgmt_wr(mgmt_wr), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata),
    .mgmt_rdata(mgmt_rdata), .mgmt_ack(mgmt_ack), .ms_fault_evt(ms_fault_evt),
    .np_tx_word(np_tx_word));
`default_nettype wire

// [testbench/gnpr_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        ref_clk, rst, soft_rst, mgmt_req, mgmt_wr, np_toggle, lp_np_load, lp_gig_hd;
    logic        lp_gig_fd, remote_rx_ok, local_rx_ok, ms_is_master, ms_fault_evt;
    logic [4:0]  mgmt_addr;
    logic [15:0] mgmt_wdata, lp_np_word;
    logic [7:0]  idle_err_cnt;
    wire  [15:0] mgmt_rdata, np_tx_word;
    wire  [2:0]  test_mode;
    wire         mgmt_ack, adv_gig_hd, adv_gig_fd, pref_master, force_master;
    wire         manual_ms_en, test_mode_valid;
    int          fails, n_checks;
    gnpr_regs dut (.ref_clk, .rst, .soft_rst, .mgmt_req, .mgmt_wr, .mgmt_addr, .mgmt_wdata,
        .mgmt_rdata, .mgmt_ack, .np_toggle, .lp_np_word, .lp_np_load, .lp_gig_hd, .lp_gig_fd,
        .remote_rx_ok, .local_rx_ok, .ms_is_master, .ms_fault_evt, .idle_err_cnt, .np_tx_word,
        .adv_gig_hd, .adv_gig_fd, .pref_master, .force_master, .manual_ms_en, .test_mode,
        .test_mode_valid);
    initial begin
        ref_clk = 0;
        forever #2 ref_clk = ~ref_clk;
    end
    task chk(input logic [15:0] v, input logic [15:0] e);
        n_checks++;
        if (v !== e) begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, v, e);
        end
    endtask
    // One request, then ack checked and read data compared with d
    task acc(input logic w, input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        {mgmt_req, mgmt_wr, mgmt_addr, mgmt_wdata} <= {1'b1, w, a, d};
        @(posedge ref_clk);
        mgmt_req <= 1'b0;
        #1;
        chk({15'h0000, mgmt_ack}, 16'h0001);
        if (!w) chk(mgmt_rdata, d);
    endtask
    task complete_run;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #4000;
        fails++;
        complete_run;
    end
    initial begin
        {rst, soft_rst, mgmt_req, mgmt_wr, np_toggle, lp_np_load, lp_gig_hd, lp_gig_fd} <= 8'h80;
        {remote_rx_ok, local_rx_ok, ms_is_master, ms_fault_evt, mgmt_addr} <= 9'h000;
        {mgmt_wdata, lp_np_word, idle_err_cnt} <= 40'h0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        acc(0, 5'h07, 16'h2001);
        acc(0, 5'h08, 16'h0000);
        acc(0, 5'h0a, 16'h0000);
        acc(0, 5'h1f, 16'h0000);
        $display("test 1 done");
        acc(1, 5'h07, 16'hffff);
        acc(0, 5'h07, 16'hb7ff);
        @(posedge ref_clk) np_toggle <= 1'b1;
        acc(1, 5'h07, 16'h0000);
        acc(0, 5'h07, 16'h0800);
        @(posedge ref_clk) np_toggle <= 1'b0;
        $display("test 2 done");
        for (int i = 0; i < 8; i++) begin
            acc(1, 5'h09, {i[2:0], 13'h0000});
            chk({test_mode_valid, test_mode}, {i < 5, i[2:0]});
        end
        acc(1, 5'h09, 16'hffff);
        chk({manual_ms_en, force_master, pref_master, adv_gig_fd, adv_gig_hd}, 5'h1f);
        acc(0, 5'h09, 16'hff00);
        acc(1, 5'h09, 16'h0a00);
        chk({manual_ms_en, force_master, pref_master, adv_gig_fd, adv_gig_hd}, 5'h0a);
        acc(0, 5'h09, 16'h0a00);
        $display("test 3 done");
        @(posedge ref_clk) {lp_np_word, lp_np_load} <= {16'h5a5a, 1'b1};
        @(posedge ref_clk) lp_np_load <= 1'b0;
        acc(1, 5'h08, 16'hffff);
        acc(0, 5'h08, 16'h5a5a);
        $display("test 4 done");
        @(posedge ref_clk);
        {lp_gig_hd, lp_gig_fd, remote_rx_ok, local_rx_ok, ms_is_master, ms_fault_evt} <= 6'h3f;
        idle_err_cnt <= 8'h3c;
        @(posedge ref_clk) ms_fault_evt <= 1'b0;
        acc(0, 5'h0a, 16'hfc3c);
        acc(0, 5'h0a, 16'h7c3c);
        $display("test 5 done");
        @(posedge ref_clk) soft_rst <= 1'b1;
        @(posedge ref_clk) soft_rst <= 1'b0;
        acc(0, 5'h07, 16'h2001);
        acc(0, 5'h09, 16'h0000);
        $display("test 6 done");
        complete_run;
    end
endmodule
`default_nettype wire
